// File: rtl/mtm_input_sync.sv
// two-stage synchroniser advanced by the prescaled timer clock, or by every bus clock in counter mode
`timescale 1ns/1ns
`default_nettype none
module mtm_input_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // advance strobe and level
  input wire logic adv,
  input wire logic din,
  output logic q
);
  typedef struct packed {
    logic ff1;
    logic ff2;
  } mtm_sync_s;
  mtm_sync_s s_r;
  mtm_sync_s s_nxt;
  // both stages move only on the adv strobe, so the lag is in timer ticks, or in bus clocks in counter mode
  always_comb
  begin
    s_nxt = s_r;
    if (adv)
    begin
      s_nxt.ff1 = din;
      s_nxt.ff2 = s_r.ff1;
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign q = s_r.ff2;
endmodule
`default_nettype wire

// File: rtl/mtm_measurement_timer.sv
// measurement timer core with apb register file
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - status request bits copy the counter into captured width or captured period
// - run status follows go, lagging through the synchroniser except in counter mode
// - signal status shows polarity-corrected signal level while run status is set, zero otherwise
// - window status shows polarity-corrected window level while run status is set, zero otherwise
// - single acquisition stops counting and clears go, except in timer mode, counter mode and unused codes; repeat keeps acquiring
// - timer mode counts every timer tick while go is set, no captures
// - counter equal to period limit sets period match flag and resets counter, except in capture mode or with stop-at-period
// - gated timer counts while signal high, captures width on signal fall
// - period-duty: fall captures width, rise captures period and loads one
// - period-duty single acquisition clears go on the completing signal rise
// - high-low: start on rise, fall captures width, next rise captures period
// - windowed measure: start on window rise, later rises capture period and restart
// - gated window: count while signal high, later window rises capture period
// - time of flight: window rise starts, signal rise captures period, double window width
// - capture mode counts from go, window edges capture, hardware never resets counter
// - counter mode counts signal pulses at bus clock rate, window fall captures width
// - gated counter counts pulses from window rise, window fall captures width
// - windowed counter: window fall captures width, later window rises capture period
// - three sticky flags with individual enables drive three interrupt lines
// - keeps running in sleep unless clocked from the stopped system clock outside counter mode
// - outside capture mode, stop-at-period holds the counter at the limit, otherwise wraps to zero
// - status reset bit clears the counter; software writes it and it reads back as zero
// - separate polarity bits invert clock, signal and window inputs
// - prescaled clock drives counter and every input synchroniser except in counter mode, where they run at bus clock rate
module mtm_measurement_timer
  import mtm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured inputs
  input wire logic ext_clk,
  input wire logic signal_in,
  input wire logic window_in,
  input wire logic sleep_req,
  // interrupt lines
  output logic width_acquired_irq,
  output logic period_acquired_irq,
  output logic period_match_irq
);
  mtm_state_s s_r;
  mtm_state_s s_nxt;
  logic [2:0] sync_in;
  logic [2:0] sync_q;
  logic step, run, run_st, sv, wv, s_rise, s_fall, w_rise, w_fall;
  logic inc, cap_w, cap_p, restart, load1, done, arm, disarm, match, sw_cnt;
  logic setup, acc, wr, src_edge, is_counter;
  logic [2:0] fl_set, fl_clr;
  logic [31:0] rd_val;
  mtm_mode_e mode;

  // address decode for the error answer; the read mux decodes the address on its own
  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a == OFF_COUNTER) ok = 1'b1;
    else if (a == OFF_CAP_PERIOD) ok = 1'b1;
    else if (a == OFF_CAP_WIDTH) ok = 1'b1;
    else if (a == OFF_PERIOD_LIMIT) ok = 1'b1;
    else if (a == OFF_CONTROL_A) ok = 1'b1;
    else if (a == OFF_CONTROL_B) ok = 1'b1;
    else if (a == OFF_STATUS) ok = 1'b1;
    else if (a == OFF_FLAGS) ok = 1'b1;
    else if (a == OFF_IRQ_ENABLE) ok = 1'b1;
    else if (a == OFF_CLOCK_SEL) ok = 1'b1;
    return ok;
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  // counter mode runs its inputs at bus clock rate, others on the timer tick
  assign mode = mtm_mode_e'(s_r.ctrl_b[CB_MODE_LO +: 4]);
  assign is_counter = (mode == MODE_COUNTER);
  assign step = is_counter | s_r.tick;
  assign sync_in[0] = signal_in ^ s_r.ctrl_a[CA_SIGNAL_POLARITY];
  assign sync_in[1] = window_in ^ s_r.ctrl_a[CA_WINDOW_POLARITY];
  assign sync_in[2] = s_r.ctrl_b[CB_GO];
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_sync
      mtm_input_sync u_sync
      (
        .clk(pclk),
        .rst_n(presetn),
        .adv(step),
        .din(sync_in[i]),
        .q(sync_q[i])
      );
    end
  endgenerate
  // edges are judged on the same tick that moves the synchronisers
  assign sv = sync_q[0];
  assign wv = sync_q[1];
  assign run_st = is_counter ? s_r.ctrl_b[CB_GO] : sync_q[2];
  assign run = s_r.ctrl_a[CA_EN] & run_st & s_r.ctrl_b[CB_GO]; // go gates at once so a finished run stops
  assign s_rise = sv & ~s_r.sig_prev;
  assign s_fall = ~sv & s_r.sig_prev;
  assign w_rise = wv & ~s_r.win_prev;
  assign w_fall = ~wv & s_r.win_prev;
  // system clock source counts as stopped in sleep
  assign src_edge = s_r.clk_sel ? ((ext_clk ^ s_r.ctrl_a[CA_CLOCK_POLARITY]) & ~s_r.clk_prev) : ~sleep_req;

  // ****************************************
  // apb strobes
  // ****************************************
  assign setup = psel & ~penable;
  assign acc = psel & penable & s_r.pready;
  assign wr = acc & pwrite;

  // read mux, sampled in the setup cycle
  always_comb
  begin
    rd_val = RD_ZERO;
    if (paddr == OFF_COUNTER) rd_val = {8'h00, s_r.cnt};
    else if (paddr == OFF_CAP_PERIOD) rd_val = {8'h00, s_r.cpr};
    else if (paddr == OFF_CAP_WIDTH) rd_val = {8'h00, s_r.cpw};
    else if (paddr == OFF_PERIOD_LIMIT) rd_val = {8'h00, s_r.pr};
    else if (paddr == OFF_CONTROL_A) rd_val = {24'h000000, s_r.ctrl_a};
    else if (paddr == OFF_CONTROL_B) rd_val = {24'h000000, s_r.ctrl_b};
    else if (paddr == OFF_STATUS) rd_val = {29'h00000000, run_st, wv & run_st, sv & run_st};
    else if (paddr == OFF_FLAGS) rd_val = {29'h00000000, s_r.flags};
    else if (paddr == OFF_IRQ_ENABLE) rd_val = {29'h00000000, s_r.irq_en};
    else if (paddr == OFF_CLOCK_SEL) rd_val = {31'h00000000, s_r.clk_sel};
  end

  // ****************************************
  // mode sequencing
  // ****************************************
  // decides per tick what the counter and capture registers do
  always_comb
  begin
    inc = 1'b0;
    cap_w = 1'b0;
    cap_p = 1'b0;
    restart = 1'b0;
    load1 = 1'b0;
    done = 1'b0;
    arm = 1'b0;
    disarm = 1'b0;
    if (step & run)
    begin
      case (mode)
        MODE_GATED_TIMER:
        begin
          inc = sv;
          cap_w = s_fall;
          done = s_fall;
        end
        MODE_PERIOD_DUTY:
        begin
          inc = s_r.armed;
          cap_w = s_fall & s_r.armed;
          cap_p = s_rise & s_r.armed;
          restart = s_rise; // arming rise too, else first width is stale
          load1 = s_rise;
          done = cap_p;
          arm = s_rise;
        end
        MODE_HIGH_LOW:
        begin
          inc = s_r.armed;
          cap_w = s_fall & s_r.armed;
          cap_p = s_rise & s_r.armed;
          restart = cap_w | cap_p;
          done = cap_p;
          arm = s_rise;
        end
        MODE_WIN_MEASURE, MODE_GATED_WIN:
        begin
          inc = s_r.armed & ((mode == MODE_WIN_MEASURE) | sv);
          cap_p = w_rise & s_r.armed;
          restart = cap_p;
          done = cap_p;
          arm = w_rise;
        end
        MODE_TIME_OF_FLIGHT:
        begin
          inc = s_r.armed;
          if (s_rise & s_r.armed)
          begin
            cap_p = 1'b1;
            restart = 1'b1;
            done = 1'b1;
            disarm = 1'b1;
          end
          else if (w_rise)
          begin
            cap_w = s_r.armed;
            restart = s_r.armed;
            arm = 1'b1;
          end
        end
        MODE_CAPTURE:
        begin
          inc = 1'b1;
          cap_p = w_rise;
          cap_w = w_fall;
          done = w_fall;
        end
        MODE_COUNTER:
        begin
          inc = s_rise;
          cap_w = w_fall;
        end
        MODE_GATED_CNT:
        begin
          inc = s_r.armed & s_rise;
          cap_w = w_fall & s_r.armed;
          done = cap_w;
          disarm = cap_w;
          arm = w_rise;
        end
        MODE_WIN_CNT:
        begin
          inc = s_r.armed & s_rise;
          cap_w = w_fall & s_r.armed;
          cap_p = w_rise & s_r.armed;
          restart = cap_p;
          done = cap_w;
          arm = w_rise;
        end
        default:
          inc = 1'b1;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  // software writes are applied after hardware so they take precedence, except flag clears, which lose to a new event
  always_comb
  begin
    s_nxt = s_r;
    match = 1'b0;
    sw_cnt = wr & ((paddr == OFF_COUNTER) | ((paddr == OFF_STATUS) & pwdata[ST_RST]));
    fl_clr = 3'h0;
    // prescaler producing the timer tick
    s_nxt.clk_prev = ext_clk ^ s_r.ctrl_a[CA_CLOCK_POLARITY];
    s_nxt.tick = 1'b0;
    if (src_edge)
    begin
      if (s_r.pre_cnt >= mtm_pre_limit(s_r.ctrl_a[CA_PS_LO +: 2]))
      begin
        s_nxt.pre_cnt = PRE_DIV1;
        s_nxt.tick = 1'b1;
      end
      else
        s_nxt.pre_cnt = s_r.pre_cnt + 3'h1;
    end
    if (step)
    begin
      s_nxt.sig_prev = sv;
      s_nxt.win_prev = wv;
    end
    // arming for modes that wait for a first edge
    if (!run)
      s_nxt.armed = 1'b0;
    else if (disarm)
      s_nxt.armed = 1'b0;
    else if (arm)
      s_nxt.armed = 1'b1;
    // counter update
    if (restart)
      s_nxt.cnt = load1 ? CNT_ONE : CNT_ZERO;
    else if (inc)
    begin
      if (s_r.cnt == s_r.pr)
      begin
        match = 1'b1;
        if (mode == MODE_CAPTURE)
          s_nxt.cnt = s_r.cnt + CNT_ONE;
        else if (s_r.ctrl_a[CA_STP])
          s_nxt.cnt = s_r.pr;
        else
          s_nxt.cnt = CNT_ZERO;
      end
      else
        s_nxt.cnt = s_r.cnt + CNT_ONE;
    end
    if (cap_w | (wr & (paddr == OFF_STATUS) & pwdata[ST_WIDTH_UPDATE_REQUEST]))
      s_nxt.cpw = s_r.cnt;
    if (cap_p | (wr & (paddr == OFF_STATUS) & pwdata[ST_PERIOD_UPDATE_REQUEST]))
      s_nxt.cpr = s_r.cnt;
    // single acquisition ends the run
    if (done & ~s_r.ctrl_b[CB_REPEAT])
      s_nxt.ctrl_b[CB_GO] = 1'b0;
    // register writes
    if (wr)
    begin
      if (paddr == OFF_COUNTER) s_nxt.cnt = pwdata[CNT_W-1:0];
      else if (paddr == OFF_PERIOD_LIMIT) s_nxt.pr = pwdata[CNT_W-1:0];
      else if (paddr == OFF_CONTROL_A) s_nxt.ctrl_a = pwdata[7:0] & CA_MASK;
      else if (paddr == OFF_CONTROL_B) s_nxt.ctrl_b = pwdata[7:0] & CB_MASK;
      else if (paddr == OFF_STATUS)
      begin
        if (pwdata[ST_RST]) s_nxt.cnt = CNT_ZERO;
      end
      else if (paddr == OFF_FLAGS) fl_clr = pwdata[2:0];
      else if (paddr == OFF_IRQ_ENABLE) s_nxt.irq_en = pwdata[2:0];
      else if (paddr == OFF_CLOCK_SEL) s_nxt.clk_sel = pwdata[0];
    end
    // sticky flags, a new event beats a clear in the same cycle
    fl_set = {match, cap_p, cap_w};
    s_nxt.flags = (s_r.flags & ~fl_clr) | fl_set;
    s_nxt.irq = s_r.flags & s_r.irq_en;
    // apb answer: ready in the first access cycle
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~reg_ok(paddr);
    if (setup)
      s_nxt.prdata = rd_val;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign width_acquired_irq = s_r.irq[FL_WIDTH];
  assign period_acquired_irq = s_r.irq[FL_PERIOD];
  assign period_match_irq = s_r.irq[FL_MATCH];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  width_request_a: assert property (wr && paddr == OFF_STATUS && pwdata[ST_WIDTH_UPDATE_REQUEST] |=> s_r.cpw == $past(s_r.cnt))
    else $error("width request did not copy counter");
  run_counter_a: assert property (is_counter && setup && paddr == OFF_STATUS
    |=> prdata[ST_TS] == $past(s_r.ctrl_b[CB_GO]))
    else $error("run status lags in counter mode");
  single_stop_a: assert property (done && !s_r.ctrl_b[CB_REPEAT] && !wr |=> !s_r.ctrl_b[CB_GO])
    else $error("go not cleared after single acquisition");
  timer_count_a: assert property (step && run && mode == MODE_TIMER && s_r.cnt != s_r.pr && !sw_cnt
    |=> s_r.cnt == 24'($past(s_r.cnt) + CNT_ONE))
    else $error("timer did not increment");
  period_wrap_a: assert property (inc && !restart && s_r.cnt == s_r.pr && mode != MODE_CAPTURE
    && !s_r.ctrl_a[CA_STP] && !sw_cnt |=> s_r.cnt == CNT_ZERO && s_r.flags[FL_MATCH])
    else $error("period match did not wrap and flag");
  hold_limit_a: assert property (inc && !restart && s_r.cnt == s_r.pr && s_r.ctrl_a[CA_STP]
    && mode != MODE_CAPTURE && !sw_cnt && !(wr && paddr == OFF_PERIOD_LIMIT) |=> s_r.cnt == s_r.pr)
    else $error("counter left the limit with stop set");
  duty_reload_a: assert property (step && run && mode == MODE_PERIOD_DUTY && s_rise && s_r.armed && !sw_cnt
    |=> s_r.cnt == CNT_ONE && s_r.cpr == $past(s_r.cnt))
    else $error("period-duty rise did not reload one");
  counter_reset_a: assert property (wr && paddr == OFF_STATUS && pwdata[ST_RST] |=> s_r.cnt == CNT_ZERO)
    else $error("counter reset bit ignored");
  flag_set_wins_a: assert property (cap_w |=> s_r.flags[FL_WIDTH] ##1 width_acquired_irq == s_r.irq_en[FL_WIDTH])
    else $error("width flag lost or irq not gated");
  apb_answer_a: assert property (setup |=> pready ##1 !pready)
    else $error("apb ready not a single access cycle");
  cover_gated_width_c: cover property (mode == MODE_GATED_TIMER && cap_w);
  cover_flight_c: cover property (mode == MODE_TIME_OF_FLIGHT && cap_p);
  cover_match_c: cover property (match ##1 period_match_irq);
  cover_counter_c: cover property (is_counter && cap_w);
endmodule
`default_nettype wire

// File: rtl/mtm_pkg.sv
// package of constants, modes and state for the measurement timer
package mtm_pkg;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_COUNTER = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CAP_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CAP_WIDTH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_LIMIT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_B = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_SEL = 8'h24;
  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int CA_PS_LO = 0;
  localparam int CA_CLOCK_POLARITY = 2;
  localparam int CA_SIGNAL_POLARITY = 3;
  localparam int CA_WINDOW_POLARITY = 4;
  localparam int CA_STP = 5;
  localparam int CA_EN = 7;
  localparam logic [7:0] CA_MASK = 8'hbf;
  localparam int CB_MODE_LO = 0;
  localparam int CB_REPEAT = 6;
  localparam int CB_GO = 7;
  localparam logic [7:0] CB_MASK = 8'hcf;
  localparam int ST_AS = 0;
  localparam int ST_WS = 1;
  localparam int ST_TS = 2;
  localparam int ST_RST = 4;
  localparam int ST_WIDTH_UPDATE_REQUEST = 6;
  localparam int ST_PERIOD_UPDATE_REQUEST = 7;
  localparam int FL_WIDTH = 0;
  localparam int FL_PERIOD = 1;
  localparam int FL_MATCH = 2;
  localparam logic [2:0] PRE_DIV1 = 3'h0;
  localparam logic [2:0] PRE_DIV2 = 3'h1;
  localparam logic [2:0] PRE_DIV4 = 3'h3;
  localparam logic [2:0] PRE_DIV8 = 3'h7;
  // operating modes, codes 11 to 15 unused
  typedef enum logic [3:0] {
    MODE_TIMER, MODE_GATED_TIMER, MODE_PERIOD_DUTY, MODE_HIGH_LOW, MODE_WIN_MEASURE,
    MODE_GATED_WIN, MODE_TIME_OF_FLIGHT, MODE_CAPTURE, MODE_COUNTER, MODE_GATED_CNT, MODE_WIN_CNT
  } mtm_mode_e;
  // whole state of the timer
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cpr;
    logic [CNT_W-1:0] cpw;
    logic [CNT_W-1:0] pr;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic clk_sel;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic [2:0] irq;
    logic [2:0] pre_cnt;
    logic clk_prev;
    logic tick;
    logic sig_prev;
    logic win_prev;
    logic armed;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mtm_state_s;
  // last prescaler count for a prescale code
  function automatic logic [2:0] mtm_pre_limit(input logic [1:0] ps);
    logic [2:0] lim;
    lim = PRE_DIV1;
    case (ps)
      2'h1: lim = PRE_DIV2;
      2'h2: lim = PRE_DIV4;
      2'h3: lim = PRE_DIV8;
      default: lim = PRE_DIV1;
    endcase
    return lim;
  endfunction
endpackage

// File: testbench/mtm_source_model.sv
// signal, window and external clock sources seen by the measurement timer
`timescale 1ns/1ns
`default_nettype none
module mtm_source_model
(
  // reference clock
  input wire logic pclk,
  // measured levels
  output logic sig,
  output logic win,
  output logic ext
);
  logic ext_run;
  // sources start idle; the external clock stands still until started
  initial
  begin
    sig = 1'b0;
    win = 1'b0;
    ext = 1'b0;
    ext_run = 1'b0;
  end
  // external clock at half the bus rate, only while started
  always @(posedge pclk)
  begin
    if (ext_run)
      ext <= ~ext;
  end
  // drive both levels after an edge and hold them for n cycles
  task automatic hold(input logic s, input logic w, input int n);
    sig <= s;
    win <= w;
    repeat (n) @(posedge pclk);
  endtask
  // starts or stops the external clock between scenarios
  task automatic run_clock(input logic on);
    ext_run <= on;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking apb testbench for the measurement timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import mtm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, rv2;
  logic err, sig, win, ext, irq_w, irq_p, irq_m;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [31:0] EN = 32'h00000080;
  mtm_source_model src (.pclk(pclk), .sig(sig), .win(win), .ext(ext));
  mtm_measurement_timer dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk(ext), .signal_in(sig), .window_in(win), .sleep_req(sleep_req),
    .width_acquired_irq(irq_w), .period_acquired_irq(irq_p), .period_match_irq(irq_m));
  // ************************************
  // clock, bus tasks and verdict
  // ************************************
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // one apb transfer; waits on pready, the watchdog cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // tests take a few hundred cycles; this span is over twenty times that
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
  // ************************************
  // test sequence
  // ************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sleep_req = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // software access, copy requests and counter reset
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("counter reset", 32'h0, rv)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    xfer(1'b1, OFF_COUNTER, 32'h00123456);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("counter rw", 32'h00123456, rv)
    xfer(1'b1, OFF_STATUS, 32'h00000040);
    xfer(1'b1, OFF_STATUS, 32'h00000080);
    xfer(1'b0, OFF_CAP_WIDTH, 32'h0);
    `CHK("width copy", 32'h00123456, rv)
    xfer(1'b0, OFF_CAP_PERIOD, 32'h0);
    `CHK("period copy", 32'h00123456, rv)
    xfer(1'b1, OFF_STATUS, 32'h00000010);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("counter clear", 32'h0, rv)
    done("registers");
    // timer mode with a short limit, signal and window toggling
    xfer(1'b1, OFF_PERIOD_LIMIT, 32'h5);
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h4);
    xfer(1'b1, OFF_CONTROL_A, EN);
    xfer(1'b1, OFF_CONTROL_B, 32'h80);
    src.hold(1'b1, 1'b1, 5);
    src.hold(1'b0, 1'b0, 30);
    xfer(1'b0, OFF_CONTROL_B, 32'h0);
    `CHK("go kept", 32'h80, rv)
    xfer(1'b0, OFF_FLAGS, 32'h0);
    `CHK("match only", 3'b100, rv[2:0])
    `CHK("match irq", 1'b1, irq_m)
    `CHK("width irq", 1'b0, irq_w)
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("wrap", 1'b1, rv <= 32'h5)
    xfer(1'b1, OFF_CONTROL_A, EN | 32'h20);
    repeat (30) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("hold at limit", 32'h5, rv)
    xfer(1'b1, OFF_CONTROL_A, EN);
    xfer(1'b1, OFF_PERIOD_LIMIT, 32'h00ffffff);
    xfer(1'b1, OFF_CONTROL_B, 32'h8f);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    rv2 = rv;
    repeat (20) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("unused mode", 1'b1, rv > rv2)
    // sleep stops the bus clock source but not the external one
    sleep_req <= 1'b1;
    @(posedge pclk); // tick already launched before sleep lands first
    xfer(1'b0, OFF_COUNTER, 32'h0);
    rv2 = rv;
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("sleep stop", rv2, rv)
    src.run_clock(1'b1);
    xfer(1'b1, OFF_CLOCK_SEL, 32'h1);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    rv2 = rv;
    repeat (40) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("sleep ext", 1'b1, rv > rv2)
    sleep_req <= 1'b0;
    src.run_clock(1'b0);
    xfer(1'b1, OFF_CLOCK_SEL, 32'h0);
    done("timer");
    // inverted inputs in gated counter mode, both lines low
    xfer(1'b1, OFF_CONTROL_A, EN | 32'h18);
    xfer(1'b1, OFF_CONTROL_B, 32'hc9);
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_STATUS, 32'h0);
    `CHK("status run", 3'b111, rv[2:0])
    xfer(1'b1, OFF_CONTROL_B, 32'h0);
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_STATUS, 32'h0);
    `CHK("status stop", 3'b000, rv[2:0])
    done("status");
    // single period and duty acquisition: high 6, period 16
    xfer(1'b1, OFF_CONTROL_A, EN);
    xfer(1'b1, OFF_FLAGS, 32'h7);
    xfer(1'b1, OFF_CONTROL_B, 32'h82);
    repeat (10) @(posedge pclk);
    repeat (3)
    begin
      src.hold(1'b1, 1'b0, 6);
      src.hold(1'b0, 1'b0, 10);
    end
    xfer(1'b0, OFF_CAP_WIDTH, 32'h0);
    `CHK("duty width", 32'h6, rv)
    xfer(1'b0, OFF_CAP_PERIOD, 32'h0);
    `CHK("duty period", 32'h10, rv)
    xfer(1'b0, OFF_CONTROL_B, 32'h0);
    `CHK("single stop", 32'h02, rv)
    xfer(1'b0, OFF_FLAGS, 32'h0);
    `CHK("acq flags", 2'b11, rv[1:0])
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h2);
    xfer(1'b0, OFF_FLAGS, 32'h0);
    `CHK("period irq", 1'b1, irq_p)
    `CHK("width irq masked", 1'b0, irq_w)
    done("period duty");
    // capture mode: window high for 9 cycles
    xfer(1'b1, OFF_CONTROL_B, 32'hc7);
    repeat (10) @(posedge pclk);
    src.hold(1'b0, 1'b1, 9);
    src.hold(1'b0, 1'b0, 8);
    xfer(1'b0, OFF_CAP_PERIOD, 32'h0);
    rv2 = rv;
    xfer(1'b0, OFF_CAP_WIDTH, 32'h0);
    `CHK("capture span", 32'h9, rv - rv2)
    xfer(1'b0, OFF_COUNTER, 32'h0);
    `CHK("no hw reset", 1'b1, rv > rv2 + 32'h9)
    xfer(1'b1, OFF_CONTROL_B, 32'h0);
    done("capture");
    // counter mode: five pulses inside the window
    src.hold(1'b0, 1'b1, 2);
    xfer(1'b1, OFF_STATUS, 32'h00000010);
    xfer(1'b1, OFF_CONTROL_B, 32'hc8);
    repeat (5) @(posedge pclk);
    repeat (5)
    begin
      src.hold(1'b1, 1'b1, 3);
      src.hold(1'b0, 1'b1, 3);
    end
    src.hold(1'b0, 1'b0, 10);
    xfer(1'b0, OFF_CAP_WIDTH, 32'h0);
    `CHK("pulse count", 32'h5, rv)
    xfer(1'b0, OFF_STATUS, 32'h0);
    `CHK("counter running", 3'b100, rv[2:0])
    xfer(1'b1, OFF_CONTROL_B, 32'h08);
    xfer(1'b0, OFF_STATUS, 32'h0);
    `CHK("counter stop no lag", 3'b000, rv[2:0])
    done("counter");
    summarize();
  end
endmodule
`default_nettype wire
